// file: logic/frcw_defs.svh
/*
  Offsets, field positions, reset values and command codes of the read
  configuration and WAIT block. Included by the package; the modules rely on that include.
*/
`ifndef FRCW_DEFS_SVH
`define FRCW_DEFS_SVH

`define FRCW_RCR_OFFSET 16'h0005
`define FRCW_RCR_RESET 16'hbfcf
`define FRCW_RCR_WMASK 16'hbfcf
`define FRCW_SR_RESET 8'h80
`define FRCW_SR_STICKY_MASK 8'h3a
`define FRCW_SR_LIVE_MASK 8'hc4
`define FRCW_SR_SEQ_ERR 8'h30
`define FRCW_CMD_RCR_SETUP 8'h60
`define FRCW_CMD_RCR_CONFIRM 8'h03
`define FRCW_CMD_CLR_STATUS 8'h50
`define FRCW_CMD_READ_ID 8'h90
`define FRCW_CMD_READ_ARRAY 8'hff
`define FRCW_CMD_READ_STATUS 8'h70
`define FRCW_BIT_MODE 15
`define FRCW_BIT_LAT_HI 13
`define FRCW_BIT_LAT_LO 11
`define FRCW_BIT_WPOL 10
`define FRCW_BIT_HOLD 9
`define FRCW_BIT_EARLY 8
`define FRCW_BIT_ORDER 7
`define FRCW_BIT_EDGE 6
`define FRCW_BIT_NOWRAP 3
`define FRCW_BIT_BL_HI 2
`define FRCW_BIT_BL_LO 0
`define FRCW_LAT_MIN 3'h2
`define FRCW_LAT_MAX 3'h6
`define FRCW_WORDS_PER_LINE 16

`endif

// file: logic/frcw_pkg.sv
/*
  Types of the read configuration and WAIT block.
  Assumes frcw_defs.svh is on the include path.
*/
`include "frcw_defs.svh"

package frcw_pkg;
  typedef struct packed {
    logic async_read_sel;
    logic [2:0] first_access_latency;
    logic wait_active_high;
    logic two_clock_hold;
    logic wait_early_release;
    logic linear_order_sel;
    logic rising_edge_sel;
    logic no_wrap_sel;
    logic [2:0] burst_length;
  } frcw_cfg_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic addr_valid_n;
    logic clk;
  } frcw_pins_s;

  typedef enum logic [1:0] {FRCW_RD_ARRAY, FRCW_RD_STATUS, FRCW_RD_ID} frcw_rdmode_e;

  typedef enum logic [1:0] {FRCW_B_IDLE, FRCW_B_LAT, FRCW_B_DATA} frcw_burst_e;
endpackage

// file: logic/frcw_sync.sv
/*
  Three-flop synchroniser for pin inputs; a change counts once the second
  and third stages agree. Assumes the pins are asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign q_o = out_q;
endmodule

`default_nettype wire

// file: logic/frcw_status.sv
/*
  Status register with set/clear policy: live bits follow the write state
  machine, error bits are sticky until the clear command or reset.
  Assumes event inputs are on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_status
  import frcw_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic dev_reset_i,
  input wire logic clear_i,
  input wire logic [7:0] wsm_live_i,
  input wire logic [7:0] wsm_set_i,
  output logic [7:0] status_o
);
  logic [7:0] status_q;
  logic [7:0] sticky_d;
  logic [7:0] held;

  // Set beats clear so an error in the clearing cycle is kept
  assign held = clear_i ? 8'h00 : (status_q & `FRCW_SR_STICKY_MASK);
  assign sticky_d = (held | wsm_set_i) & `FRCW_SR_STICKY_MASK;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status_q <= `FRCW_SR_RESET;
    end
    else if (dev_reset_i)
    begin
      status_q <= `FRCW_SR_RESET;
    end
    else
    begin
      status_q <= (wsm_live_i & `FRCW_SR_LIVE_MASK) | sticky_d;
    end
  end

  assign status_o = status_q;
endmodule

`default_nettype wire

// file: logic/frcw_top.sv
/*
  Read configuration register, command handling for it and for status
  clear, and the WAIT pin sequencer for synchronous bursts.
  Assumes a host that drives the bus pins, writes commands on DQ[7:0]
  at the we_n rising edge, and samples data and WAIT.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_top
  import frcw_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic dev_rst_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic addr_valid_n_i,
  input wire logic link_clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] array_data_i,
  input wire logic [7:0] wsm_live_i,
  input wire logic [7:0] wsm_set_i,
  output logic [15:0] array_addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  output logic [15:0] read_config_reg_o,
  output logic [7:0] status_reg_o
);
  localparam frcw_pins_s PIN_INIT = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      addr_valid_n: 1'b1, clk: 1'b0};

  frcw_pins_s pins_raw;
  frcw_pins_s pins;
  frcw_pins_s pins_q;
  logic dev_rst_n_s;
  logic [15:0] rcr_q;
  logic [15:0] rcr_d;
  logic setup_q;
  frcw_rdmode_e rdmode_q;
  frcw_burst_e bstate_q;
  logic [2:0] lat_cnt_q;
  logic hold_cnt_q;
  logic [15:0] baddr_q;
  logic [15:0] dout_q;
  logic dout_en_q;
  logic wait_asserted_q;
  logic [7:0] cmd;
  logic we_rise;
  logic active_edge;
  logic adv_rise;
  logic bus_active;
  logic clr_status;
  logic [15:0] read_word;
  logic [15:0] next_addr;
  logic last_hold;
  logic seq_err;
  logic [7:0] status_sets;
  frcw_cfg_s cfg;

  function automatic logic [15:0] frcw_burst_next(input logic [15:0] a,
                                                  input logic [2:0] bl,
                                                  input logic nowrap);
    logic [15:0] inc;
    logic [15:0] mask;
    inc = a + 16'h0001;
    case (bl)
      3'h1: mask = 16'h0003;
      3'h2: mask = 16'h0007;
      3'h3: mask = 16'h000f;
      default: mask = 16'h0000;
    endcase
    if (nowrap || mask == 16'h0000)
    begin
      frcw_burst_next = inc;
    end
    else
    begin
      frcw_burst_next = (a & ~mask) | (inc & mask);
    end
  endfunction

  assign pins_raw = '{ce_n: ce_n_i, oe_n: oe_n_i, we_n: we_n_i,
                      addr_valid_n: addr_valid_n_i, clk: link_clk_i};

  frcw_sync #(.WIDTH(5), .INIT(PIN_INIT)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  frcw_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .d_i(dev_rst_n_i),
    .q_o(dev_rst_n_s)
  );

  assign cfg = '{async_read_sel: rcr_q[`FRCW_BIT_MODE],
                 first_access_latency: rcr_q[`FRCW_BIT_LAT_HI:`FRCW_BIT_LAT_LO],
                 wait_active_high: rcr_q[`FRCW_BIT_WPOL],
                 two_clock_hold: rcr_q[`FRCW_BIT_HOLD],
                 wait_early_release: rcr_q[`FRCW_BIT_EARLY],
                 linear_order_sel: rcr_q[`FRCW_BIT_ORDER],
                 rising_edge_sel: rcr_q[`FRCW_BIT_EDGE],
                 no_wrap_sel: rcr_q[`FRCW_BIT_NOWRAP],
                 burst_length: rcr_q[`FRCW_BIT_BL_HI:`FRCW_BIT_BL_LO]};

  // Commands are latched on the we_n rising edge while the chip is selected
  assign cmd = dq_i[7:0];
  assign we_rise = pins.we_n & ~pins_q.we_n & ~pins.ce_n;
  assign adv_rise = pins.addr_valid_n & ~pins_q.addr_valid_n & ~pins.ce_n;
  assign active_edge = cfg.rising_edge_sel ? (pins.clk & ~pins_q.clk)
                                           : (~pins.clk & pins_q.clk);
  assign bus_active = ~pins.ce_n & ~pins.oe_n & dev_rst_n_s;
  assign clr_status = we_rise & (cmd == `FRCW_CMD_CLR_STATUS);
  assign seq_err = we_rise & setup_q & (cmd != `FRCW_CMD_RCR_CONFIRM);
  assign status_sets = wsm_set_i | (seq_err ? `FRCW_SR_SEQ_ERR : 8'h00);
  // Reserved bits are forced to zero rather than stored as written
  assign rcr_d = addr_i & `FRCW_RCR_WMASK;

  frcw_status u_status (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .dev_reset_i(~dev_rst_n_s),
    .clear_i(clr_status),
    .wsm_live_i(wsm_live_i),
    .wsm_set_i(status_sets),
    .status_o(status_reg_o)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pins_q <= PIN_INIT;
    end
    else
    begin
      pins_q <= pins;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rcr_q <= `FRCW_RCR_RESET;
      setup_q <= 1'b0;
      rdmode_q <= FRCW_RD_ARRAY;
    end
    else if (!dev_rst_n_s)
    begin
      rcr_q <= `FRCW_RCR_RESET;
      setup_q <= 1'b0;
      rdmode_q <= FRCW_RD_ARRAY;
    end
    else if (we_rise)
    begin
      setup_q <= (cmd == `FRCW_CMD_RCR_SETUP) && !setup_q;
      if (setup_q && cmd == `FRCW_CMD_RCR_CONFIRM)
      begin
        rcr_q <= rcr_d;
        rdmode_q <= FRCW_RD_ARRAY;
      end
      else if (!setup_q && cmd == `FRCW_CMD_READ_ID)
      begin
        rdmode_q <= FRCW_RD_ID;
      end
      else if (!setup_q && cmd == `FRCW_CMD_READ_STATUS)
      begin
        rdmode_q <= FRCW_RD_STATUS;
      end
      else if (!setup_q && cmd == `FRCW_CMD_READ_ARRAY)
      begin
        rdmode_q <= FRCW_RD_ARRAY;
      end
    end
  end

  // Only the configuration word at offset 0005 is decoded in identifier space; other addresses read zero
  assign read_word = (rdmode_q == FRCW_RD_STATUS) ? {8'h00, status_reg_o}
                   : (rdmode_q == FRCW_RD_ID && baddr_q == `FRCW_RCR_OFFSET) ? rcr_q
                   : (rdmode_q == FRCW_RD_ID) ? 16'h0000
                   : array_data_i;
  assign next_addr = frcw_burst_next(baddr_q, cfg.burst_length, cfg.no_wrap_sel);
  assign last_hold = ~cfg.two_clock_hold | hold_cnt_q;

  // Burst sequencer; address latch on the addr_valid_n rising edge, latency and data steps on the selected link clock edge
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bstate_q <= FRCW_B_IDLE;
      lat_cnt_q <= 3'h0;
      hold_cnt_q <= 1'b0;
      baddr_q <= 16'h0000;
      dout_q <= 16'h0000;
      dout_en_q <= 1'b0;
      wait_asserted_q <= 1'b0;
    end
    else if (!bus_active && pins.ce_n)
    begin
      bstate_q <= FRCW_B_IDLE;
      dout_en_q <= 1'b0;
      wait_asserted_q <= 1'b0;
      if (adv_rise)
      begin
        baddr_q <= addr_i;
      end
    end
    else if (cfg.async_read_sel)
    begin
      bstate_q <= FRCW_B_IDLE;
      wait_asserted_q <= 1'b0;
      dout_en_q <= ~pins.oe_n;
      dout_q <= read_word;
      if (!pins.addr_valid_n || adv_rise)
      begin
        baddr_q <= addr_i;
      end
    end
    else if (adv_rise)
    begin
      // A new address restarts the burst and the latency count
      baddr_q <= addr_i;
      bstate_q <= FRCW_B_LAT;
      lat_cnt_q <= cfg.first_access_latency;
      hold_cnt_q <= 1'b0;
      dout_en_q <= 1'b0;
      wait_asserted_q <= 1'b1;
    end
    else if (active_edge && bus_active)
    begin
      case (bstate_q)
        FRCW_B_LAT:
        begin
          lat_cnt_q <= lat_cnt_q - 3'h1;
          // Early release drops WAIT one data cycle before the word
          if (cfg.wait_early_release && lat_cnt_q == 3'h2)
          begin
            wait_asserted_q <= 1'b0;
          end
          if (lat_cnt_q <= 3'h1)
          begin
            bstate_q <= FRCW_B_DATA;
            // Step ahead so the array already shows the next word
            baddr_q <= next_addr;
            dout_q <= read_word;
            dout_en_q <= 1'b1;
            wait_asserted_q <= 1'b0;
          end
        end
        FRCW_B_DATA:
        begin
          hold_cnt_q <= cfg.two_clock_hold & ~hold_cnt_q;
          if (last_hold)
          begin
            baddr_q <= next_addr;
            dout_q <= (rdmode_q == FRCW_RD_ARRAY) ? array_data_i : dout_q;
          end
        end
        default:
        begin
          bstate_q <= FRCW_B_IDLE;
        end
      endcase
    end
  end

  assign array_addr_o = baddr_q;
  assign dq_o = dout_q;
  assign dq_oe_o = dout_en_q & ~pins.oe_n & ~pins.ce_n;
  assign wait_o = wait_asserted_q & ~cfg.async_read_sel ? cfg.wait_active_high
                                                        : ~cfg.wait_active_high;
  assign wait_oe_o = ~pins.ce_n & ~pins.oe_n & dev_rst_n_s;
  assign read_config_reg_o = rcr_q;
endmodule

`default_nettype wire

// file: sim/frcw_top_monitor.sv
/*
  Checker for the read configuration and WAIT block.
  Bound to frcw_top; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_top_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic dev_rst_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] wsm_live_i,
  input wire logic [7:0] wsm_set_i,
  input wire logic dq_oe_o,
  input wire logic wait_o,
  input wire logic wait_oe_o,
  input wire logic [15:0] read_config_reg_o,
  input wire logic [7:0] status_reg_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Six cycles cover the pin synchroniser
  property p_ce_float;
    ce_n_i [*6] |-> !wait_oe_o && !dq_oe_o;
  endproperty
  a_ce_float: assert property (p_ce_float) else $error("pins driven, chip off");

  property p_oe_float;
    oe_n_i [*6] |-> !wait_oe_o;
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("wait driven, output off");

  property p_async_level;
    read_config_reg_o[15] && wait_oe_o |-> wait_o == !read_config_reg_o[10];
  endproperty
  a_async_level: assert property (p_async_level) else $error("async wait asserted");

  property p_dev_cfg;
    !dev_rst_n_i [*5] |=> read_config_reg_o == 16'hbfcf;
  endproperty
  a_dev_cfg: assert property (p_dev_cfg) else $error("config not reset");

  property p_dev_sr;
    !dev_rst_n_i [*5] |=> status_reg_o == 8'h80;
  endproperty
  a_dev_sr: assert property (p_dev_sr) else $error("status not reset");

  property p_sticky;
    dev_rst_n_i && (wsm_set_i & 8'h3a) != 8'h00 |=>
      (status_reg_o & $past(wsm_set_i) & 8'h3a) == ($past(wsm_set_i) & 8'h3a);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error bit not set");

  property p_live;
    dev_rst_n_i && $changed(wsm_live_i) |-> ##2 (status_reg_o & 8'hc4) == (wsm_live_i & 8'hc4);
  endproperty
  a_live: assert property (p_live) else $error("live bits not followed");

  property p_rsvd;
    (read_config_reg_o & 16'h4030) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved config bit set");
endmodule

`default_nettype wire

// file: sim/frcw_array_model.sv
/*
  Array behind the block: a word per address.
  Answers in the same cycle as the address.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_array_model #(
  parameter logic [15:0] KEY = 16'h5a5a
) (
  input wire logic [15:0] addr_i,
  output logic [15:0] data_o
);
  // Pattern lets every word read back name its own address
  assign data_o = addr_i ^ KEY;
endmodule

`default_nettype wire

// file: sim/frcw_top_bench.sv
/*
  Self-checking bench for frcw_top with array model and checker.
  Assumes the pins are sampled through the block's synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none

module frcw_top_bench;
  import frcw_pkg::*;
  localparam logic [15:0] KEY = 16'h3c96;
  typedef struct {int kind; logic [15:0] v;} frcw_exp_s;
  logic ref_clk_i = 0, arst_n_i = 0, dev_rst_n_i = 1, ce_n_i = 1, oe_n_i = 1;
  logic we_n_i = 1, addr_valid_n_i = 1, link_clk_i = 0, link_run = 0;
  logic [15:0] addr_i = 0, dq_i = 0, array_data_i, array_addr_o, dq_o;
  logic [15:0] read_config_reg_o, rand_cfg, burst_a;
  logic [7:0] wsm_live_i = 8'h80, wsm_set_i = 8'h00, status_reg_o;
  logic dq_oe_o, wait_o, wait_oe_o;
  logic [1:0] lcnt = 2'h0;
  int num_errors = 0, checked = 0, seed = 47, i;
  frcw_exp_s exp_q[$];
  frcw_exp_s e;
  event chk_ev;

  frcw_top u_dut (.ref_clk_i, .arst_n_i, .dev_rst_n_i, .ce_n_i, .oe_n_i, .we_n_i,
    .addr_valid_n_i, .link_clk_i, .addr_i, .dq_i, .array_data_i, .wsm_live_i,
    .wsm_set_i, .array_addr_o, .dq_o, .dq_oe_o, .wait_o, .wait_oe_o,
    .read_config_reg_o, .status_reg_o);
  frcw_array_model #(.KEY(KEY)) u_arr (.addr_i(array_addr_o), .data_o(array_data_i));

  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Link clock runs only within a burst, 200 ns period
  always @(posedge ref_clk_i)
    if (link_run)
    begin
      lcnt <= lcnt + 2'h1;
      if (lcnt == 2'h3)
        link_clk_i <= ~link_clk_i;
    end

  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Slow enough for the three-flop pin synchronisers
  task cmd(input logic [7:0] c, input logic [15:0] a);
    ce_n_i <= 1'b0;
    we_n_i <= 1'b0;
    dq_i <= {8'h00, c};
    addr_i <= a;
    tick(6);
    we_n_i <= 1'b1;
    tick(6);
    ce_n_i <= 1'b1;
    tick(6);
  endtask

  task expect_v(input int k, input logic [15:0] v);
    exp_q.push_back('{k, v});
    @(negedge ref_clk_i);
    -> chk_ev;
    @(posedge ref_clk_i);
  endtask

  task cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task stop_test;
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    forever
    begin
      @(chk_ev);
      e = exp_q.pop_front();
      case (e.kind)
        0: cmp("config", e.v, read_config_reg_o);
        1: cmp("status", e.v, {8'h00, status_reg_o});
        2: cmp("data", e.v, dq_o);
        default: cmp("wait", e.v, {15'h0000, wait_o});
      endcase
    end
  end

  initial
  begin
    #200000;
    num_errors++;
    stop_test;
  end

  initial
  begin
    tick(20);
    arst_n_i <= 1'b1;
    tick(6);
    expect_v(0, 16'hbfcf);
    expect_v(1, 16'h0080);
    rand_cfg = ($random(seed) & 16'hbfcf) | 16'h8080;
    cmd(8'h60, 16'h0000);
    cmd(8'h03, rand_cfg);
    expect_v(0, rand_cfg);
    cmd(8'h90, 16'h0000);
    addr_i <= 16'h0005;
    addr_valid_n_i <= 1'b0;
    ce_n_i <= 1'b0;
    oe_n_i <= 1'b0;
    tick(8);
    expect_v(2, rand_cfg);
    expect_v(3, {15'h0000, ~rand_cfg[10]});
    ce_n_i <= 1'b1;
    oe_n_i <= 1'b1;
    addr_valid_n_i <= 1'b1;
    wsm_set_i <= 8'h3a;
    tick(1);
    wsm_set_i <= 8'h00;
    tick(3);
    expect_v(1, 16'h00ba);
    wsm_live_i <= 8'h44;
    tick(4);
    expect_v(1, 16'h007e);
    wsm_live_i <= 8'h00;
    tick(4);
    expect_v(1, 16'h003a);
    cmd(8'h50, 16'h0000);
    expect_v(1, 16'h0000);
    cmd(8'h60, 16'h0000);
    cmd(8'h70, 16'h0000);
    expect_v(1, 16'h0030);
    expect_v(0, rand_cfg);
    dev_rst_n_i <= 1'b0;
    tick(8);
    expect_v(0, 16'hbfcf);
    expect_v(1, 16'h0080);
    dev_rst_n_i <= 1'b1;
    wsm_live_i <= 8'h80;
    tick(8);
    // Burst: latency code 3, wait high, one-clock hold, on-time release, 4 words
    cmd(8'h50, 16'h0000);
    expect_v(1, 16'h0080);
    cmd(8'h60, 16'h0000);
    cmd(8'h03, 16'h1cc9);
    expect_v(0, 16'h1cc9);
    cmd(8'hff, 16'h0000);
    burst_a = $random(seed) & 16'h0ff0;
    ce_n_i <= 1'b0;
    addr_valid_n_i <= 1'b0;
    addr_i <= burst_a;
    link_run <= 1'b1;
    tick(8);
    addr_valid_n_i <= 1'b1;
    oe_n_i <= 1'b0;
    tick(10);
    expect_v(3, 16'h0001);
    i = 0;
    while (wait_o !== 1'b0 && i < 200)
    begin
      @(negedge ref_clk_i);
      i++;
    end
    expect_v(2, burst_a ^ KEY);
    expect_v(3, 16'h0000);
    @(posedge link_clk_i);
    tick(6);
    expect_v(2, (burst_a + 16'h0001) ^ KEY);
    ce_n_i <= 1'b1;
    oe_n_i <= 1'b1;
    link_run <= 1'b0;
    tick(8);
    stop_test;
  end
endmodule

bind frcw_top frcw_top_monitor u_mon (.ref_clk_i, .arst_n_i, .dev_rst_n_i, .ce_n_i,
  .oe_n_i, .wsm_live_i, .wsm_set_i, .dq_oe_o, .wait_o, .wait_oe_o,
  .read_config_reg_o, .status_reg_o);

`default_nettype wire
